// *** bench/fotp_ctrl_properties.sv ***
`timescale 1ns/1ns
`include "fotp_defs.vh"
module fotp_ctrl_chk #(
	parameter AW = 24,
	parameter DW = 16
) (
	// watched ports
	input wire          mclk_i,
	input wire          reset_n_i,
	input wire          req_i,
	input wire [4:0]    op_i,
	input wire          busy_o,
	input wire          done_o,
	input wire [AW-1:0] fl_addr_o,
	input wire [DW-1:0] fl_dq_o,
	input wire          fl_dq_oe_n_o,
	input wire          fl_ce_n_o,
	input wire          fl_we_n_o,
	input wire          fl_oe_n_o
);
	reg otp_q;
	always @(posedge mclk_i or negedge reset_n_i)
		if (!reset_n_i)
			otp_q <= 1'b0;
		else if (req_i && !busy_o)
			otp_q <= op_i == `FOTP_OP_OTP_PROG || op_i == `FOTP_OP_OTP_LOCK;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	property p_accept; req_i && !busy_o |=> busy_o; endproperty
	a_accept: assert property (p_accept) else $error("order not taken");
	property p_finish; $rose(busy_o) |-> ##[2:40] done_o; endproperty
	a_finish: assert property (p_finish) else $error("order never done");
	property p_done; done_o |=> !done_o; endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
	property p_idle; !busy_o |-> fl_we_n_o && fl_oe_n_o; endproperty
	a_idle: assert property (p_idle) else $error("strobe while idle");
	property p_we_ce; !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o && !fl_dq_oe_n_o; endproperty
	a_we_ce: assert property (p_we_ce) else $error("bad write strobes");
	property p_rd; !fl_oe_n_o |-> !fl_ce_n_o && fl_dq_oe_n_o; endproperty
	a_rd: assert property (p_rd) else $error("bad read strobes");
	property p_we_width; $fell(fl_we_n_o) |-> !fl_we_n_o [*2] ##1 fl_we_n_o; endproperty
	a_we_width: assert property (p_we_width) else $error("write pulse width");
	property p_wr_hold; !fl_we_n_o ##1 !fl_we_n_o |-> $stable(fl_addr_o) && $stable(fl_dq_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write lines moved");
	property p_otp_addr; otp_q && !fl_we_n_o && fl_dq_o != 16'h00C0
		|-> fl_addr_o[AW-1:9] == 0 && fl_addr_o[8]; endproperty
	a_otp_addr: assert property (p_otp_addr) else $error("area address bits");
	cover property (otp_q && done_o);
	cover property (!otp_q && done_o);
	cover property ($rose(fl_oe_n_o));
endmodule // fotp_ctrl_chk
bind fotp_ctrl fotp_ctrl_chk #(.AW(AW), .DW(DW)) u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.req_i(req_i), .op_i(op_i), .busy_o(busy_o), .done_o(done_o), .fl_addr_o(fl_addr_o),
	.fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o),
	.fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));

// *** bench/fotp_flash_model.sv ***
`timescale 1ns/1ns
module fotp_flash_model #(
	parameter DLY = 0
) (
	// pins
	input  wire [23:0] fl_addr_i,
	input  wire [15:0] fl_wdata_i,
	input  wire        fl_ce_n_i,
	input  wire        fl_we_n_i,
	input  wire        fl_oe_n_i,
	input  wire        byte_mode_i,
	input  wire        program_enable_supply_i,
	output wire [15:0] fl_rdata_o
);
	reg [7:0]  otp [0:17];
	reg [15:0] arr [0:255];
	reg [7:0]  sr;
	reg [1:0]  mode;
	reg [15:0] pend, prev_d, last_d, rd;
	reg [23:0] prev_a, last_a;
	reg [4:0]  bi;
	integer    i;
	wire [4:0] rbi = byte_mode_i ? fl_addr_i[4:0] : {fl_addr_i[4:1], 1'b0};
	initial begin
		for (i = 0; i < 256; i = i + 1) arr[i] = 16'hFFFF;
		for (i = 0; i < 18; i = i + 1) otp[i] = (i < 10) ? i * 8'h11 : 8'hFF;
		otp[0] = 8'hFE;
		otp[1] = 8'hFF;
		sr = 8'h80;
		mode = 2'd0;
		pend = 16'h0000;
	end
	always @(negedge fl_we_n_i) begin
		#1;
		if (!fl_ce_n_i) begin
			prev_a = last_a;
			prev_d = last_d;
			last_a = fl_addr_i;
			last_d = fl_wdata_i;
			bi = byte_mode_i ? fl_addr_i[4:0] : {fl_addr_i[4:1], 1'b0};
			if (pend == 16'h00C0) begin
				if (fl_addr_i[23:8] != 16'h0001 || bi > 5'd17)
					sr = sr | 8'h10;
				else if ((bi > 1 && bi < 10 && !otp[0][0]) || (bi > 9 && !otp[0][1]))
					sr = sr | 8'h12;
				else begin
					otp[bi] = otp[bi] & fl_wdata_i[7:0];
					if (!byte_mode_i) otp[bi + 1] = otp[bi + 1] & fl_wdata_i[15:8];
				end
			end else if (!program_enable_supply_i && (pend == 16'h0040 || pend == 16'h0010))
				sr = sr | 8'h10;
			else if (!program_enable_supply_i && pend == 16'h0020)
				sr = sr | 8'h20;
			else if (pend == 16'h0040 || pend == 16'h0010)
				arr[fl_addr_i[7:0]] = arr[fl_addr_i[7:0]] & fl_wdata_i;
			else if (pend == 16'h0020 && fl_wdata_i == 16'h00D0)
				for (i = 0; i < 256; i = i + 1) arr[i] = 16'hFFFF;
			if (pend != 16'h0000) begin
				pend = 16'h0000;
				sr[7] = 1'b1;
			end else case (fl_wdata_i)
				16'h00FF: mode = 2'd0;
				16'h0090, 16'h0098: mode = 2'd1;
				16'h0070, 16'h00B0, 16'h00D0: mode = 2'd2;
				16'h0050: sr = 8'h80;
				default: begin
					pend = fl_wdata_i;
					mode = 2'd2;
				end
			endcase
		end
	end
	always @* case (mode)
		2'd0: rd = arr[fl_addr_i[7:0]];
		2'd1: rd = fl_addr_i[23:8] != 16'h0001 ? 16'h0000 :
			byte_mode_i ? {8'h00, otp[rbi]} : {otp[rbi + 1], otp[rbi]};
		default: rd = {8'h00, sr};
	endcase
	assign #(DLY) fl_rdata_o = (!fl_ce_n_i && !fl_oe_n_i) ? rd : ~rd;
endmodule // fotp_flash_model

// *** bench/tb.sv ***
`timescale 1ns/1ns
`include "fotp_defs.vh"
module tb;
	reg         mclk_i = 0, reset_n_i = 0, req_i = 0, byte_mode_i = 0, pen = 1;
	reg  [4:0]  op_i = 0, o;
	reg  [23:0] addr_i = 0, a;
	reg  [15:0] data_i = 0, d;
	reg  [31:0] e;
	wire        busy_o, done_o, addr_err_o, dq_oe_n, ce_n, we_n, oe_n;
	wire [15:0] rdata_o, dq_o, dq_i;
	wire [23:0] fa;
	integer     failures = 0, compares = 0, seed = 55, cyc = 0, k, n;
	fotp_ctrl dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i), .op_i(op_i),
		.addr_i(addr_i), .data_i(data_i), .byte_mode_i(byte_mode_i), .busy_o(busy_o),
		.done_o(done_o), .rdata_o(rdata_o), .addr_err_o(addr_err_o), .fl_addr_o(fa),
		.fl_dq_o(dq_o), .fl_dq_oe_n_o(dq_oe_n), .fl_dq_i(dq_i), .fl_ce_n_o(ce_n),
		.fl_we_n_o(we_n), .fl_oe_n_o(oe_n));
	fotp_flash_model #(.DLY(30)) mdl (.fl_addr_i(fa), .fl_wdata_i(dq_o), .fl_ce_n_i(ce_n),
		.fl_we_n_i(we_n), .fl_oe_n_i(oe_n), .byte_mode_i(byte_mode_i),
		.program_enable_supply_i(pen), .fl_rdata_o(dq_i));
	initial forever #20 mclk_i = ~mclk_i;
	task conclude;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	always @(posedge mclk_i) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			failures = failures + 1;
			conclude;
		end
	end
	task chk(input string nm, input [23:0] x, input [23:0] y);
		begin
			compares = compares + 1;
			if (x !== y) begin
				failures = failures + 1;
				$display("BAD %s exp %h got %h", nm, x, y);
			end
		end
	endtask
	task run(input [4:0] op, input [23:0] ad, input [15:0] dt);
		begin
			op_i = op;
			addr_i = ad;
			data_i = dt;
			req_i = 1'b1;
			@(posedge mclk_i);
			#2 req_i = 1'b0;
			n = 0;
			while (done_o !== 1'b1 && n < 60) begin
				@(posedge mclk_i);
				#2 n = n + 1;
			end
			if (n == 60) chk("done", 1, 0);
		end
	endtask
	task stat(input [7:0] x);
		begin
			run(`FOTP_OP_READ_STATUS, 0, 0);
			run(`FOTP_OP_READ, 0, 0);
			chk("status", x, rdata_o[7:0]);
		end
	endtask
	function [31:0] cmd(input [4:0] op, input [15:0] dt);
		case (op)
			`FOTP_OP_READ_ARRAY: cmd = {16'h0, `FOTP_CMD_READ_ARRAY};
			`FOTP_OP_READ_ID: cmd = {16'h0, `FOTP_CMD_READ_ID};
			`FOTP_OP_READ_STATUS: cmd = {16'h0, `FOTP_CMD_READ_STATUS};
			`FOTP_OP_CLR_STATUS: cmd = {16'h0, `FOTP_CMD_CLR_STATUS};
			`FOTP_OP_QUERY: cmd = {16'h0, `FOTP_CMD_QUERY};
			`FOTP_OP_SUSPEND: cmd = {16'h0, `FOTP_CMD_SUSPEND};
			`FOTP_OP_RESUME: cmd = {16'h0, `FOTP_CMD_CONFIRM};
			`FOTP_OP_PROG: cmd = {dt[15] ? 16'h0010 : 16'h0040, 1'b0, dt[14:0]};
			`FOTP_OP_BUF_PROG: cmd = {`FOTP_CMD_BUF_SETUP, `FOTP_CMD_CONFIRM};
			`FOTP_OP_ERASE: cmd = {`FOTP_CMD_ERASE_SETUP, `FOTP_CMD_CONFIRM};
			`FOTP_OP_LOCK_BLOCK: cmd = {`FOTP_CMD_LOCK_SETUP, `FOTP_CMD_LOCK_BLOCK};
			`FOTP_OP_UNLOCK_ALL: cmd = {`FOTP_CMD_LOCK_SETUP, `FOTP_CMD_CONFIRM};
			`FOTP_OP_STS_CFG: cmd = {`FOTP_CMD_STS_SETUP, dt};
			default: cmd = {`FOTP_CMD_LOCK_SETUP, `FOTP_CMD_ECR_CONFIRM};
		endcase
	endfunction
	initial begin
		repeat (12) @(posedge mclk_i);
		#2 reset_n_i = 1'b1;
		chk("idle pins", 4'hF, {ce_n, we_n, oe_n, busy_o === 1'b0});
		for (k = 0; k < 32; k = k + 1) begin
			o = k % 16;
			a = $random(seed);
			d = $random(seed);
			if (o != `FOTP_OP_OTP_PROG && o != `FOTP_OP_OTP_LOCK) begin
				run(o, a, d);
				e = cmd(o, d);
				chk("data", e[15:0], mdl.last_d);
				chk("addr", a, mdl.last_a);
				if (e[31:16] != 16'h0) begin
					chk("setup", e[31:16], mdl.prev_d);
					chk("same addr", mdl.prev_a, mdl.last_a);
				end
			end
		end
		$display("test command codes done");
		run(`FOTP_OP_CLR_STATUS, 0, 0);
		d = $random(seed);
		run(`FOTP_OP_OTP_PROG, 24'd5, d);
		chk("otp setup", `FOTP_CMD_OTP_SETUP, mdl.prev_d);
		chk("otp addr", 24'h10A, mdl.last_a);
		chk("addr err", 0, addr_err_o);
		run(`FOTP_OP_READ, 0, 0);
		chk("post status", 8'h80, rdata_o[7:0]);
		run(`FOTP_OP_OTP_LOCK, 0, 0);
		chk("lock data", `FOTP_LOCK_USER_VALUE, mdl.last_d);
		chk("lock addr", 24'h100, mdl.last_a);
		run(`FOTP_OP_OTP_PROG, 24'd5, 16'h0000);
		stat(8'h92);
		run(`FOTP_OP_CLR_STATUS, 0, 0);
		run(`FOTP_OP_READ_ID, 0, 0);
		run(`FOTP_OP_READ, 24'h10A, 0);
		chk("otp word", d, rdata_o);
		run(`FOTP_OP_READ, 24'h102, 0);
		chk("factory word", 16'h3322, rdata_o);
		run(`FOTP_OP_OTP_PROG, 24'd9, 0);
		chk("addr err", 1, addr_err_o);
		stat(8'h90);
		run(`FOTP_OP_CLR_STATUS, 0, 0);
		byte_mode_i = 1'b1;
		run(`FOTP_OP_OTP_PROG, 24'h11, 0);
		chk("byte addr", 24'h111, mdl.last_a);
		stat(8'h92);
		run(`FOTP_OP_CLR_STATUS, 0, 0);
		byte_mode_i = 1'b0;
		$display("test protection area done");
		pen = 1'b0;
		run(`FOTP_OP_PROG, 24'h10, 16'h1234);
		stat(8'h90);
		run(`FOTP_OP_ERASE, 24'h10, 0);
		stat(8'hB0);
		pen = 1'b1;
		run(`FOTP_OP_CLR_STATUS, 0, 0);
		stat(8'h80);
		$display("test supply guard done");
		conclude;
	end
endmodule // tb

// *** verilog/fotp_ctrl.v ***
`timescale 1ns/1ns
`include "fotp_defs.vh"
module fotp_ctrl #(
	parameter AW = 24,
	parameter DW = 16
) (
	// clock and reset
	input  wire          mclk_i,
	input  wire          reset_n_i,
	// user orders
	input  wire          req_i,
	input  wire [4:0]    op_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] data_i,
	input  wire          byte_mode_i,
	output reg           busy_o,
	output reg           done_o,
	output reg  [DW-1:0] rdata_o,
	output reg           addr_err_o,
	// flash pins
	output reg  [AW-1:0] fl_addr_o,
	output reg  [DW-1:0] fl_dq_o,
	output reg           fl_dq_oe_n_o,
	input  wire [DW-1:0] fl_dq_i,
	output reg           fl_ce_n_o,
	output reg           fl_we_n_o,
	output reg           fl_oe_n_o
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_C1   = 3'h1;
	localparam [2:0] S_W1   = 3'h2;
	localparam [2:0] S_C2   = 3'h3;
	localparam [2:0] S_W2   = 3'h4;
	localparam [2:0] S_FIN  = 3'h5;
	reg  [2:0]    state_q;
	reg  [4:0]    op_q;
	reg  [AW-1:0] addr_q;
	reg           two_q;
	reg           rd_q;
	reg  [DW-1:0] cmd1_q;
	reg  [AW-1:0] a2_q;
	reg  [DW-1:0] d2_q;
	reg           cyc_start_q;
	reg           cyc_wr_q;
	reg  [AW-1:0] cyc_addr_q;
	reg  [DW-1:0] cyc_data_q;
	wire          cyc_done;
	wire [DW-1:0] cyc_rdata;
	wire [AW-1:0] cyc_fl_addr;
	wire [DW-1:0] cyc_fl_dq;
	wire          cyc_fl_oe_n;
	wire          cyc_ce_n;
	wire          cyc_we_n;
	wire          cyc_oe_n;
	reg  [DW-1:0] c1;
	reg           two;
	reg           rd;
	reg  [AW-1:0] a2;
	reg  [DW-1:0] d2;
	reg           aerr;
	reg  [AW-1:0] otp_addr;
	// otp address space check in either width
	always @* begin
		aerr     = 1'b0;
		otp_addr = {AW{1'b0}};
		if (byte_mode_i) begin
			otp_addr = {{(AW-9){1'b0}}, `FOTP_AREA_BASE} + {{(AW-5){1'b0}}, addr_i[4:0]};
			aerr     = (addr_i[4:0] > 5'h11);
		end else begin
			otp_addr = {{(AW-9){1'b0}}, `FOTP_AREA_BASE} + {{(AW-5){1'b0}}, addr_i[3:0], 1'b0};
			aerr     = (addr_i[3:0] > 4'h8);
		end
		otp_addr = otp_addr & {{(AW-9){1'b0}}, 9'h1FF};
	end
	// command sequence per operation
	always @* begin
		c1  = `FOTP_CMD_READ_ARRAY;
		two = 1'b0;
		rd  = 1'b0;
		a2  = addr_i;
		d2  = data_i;
		case (op_i)
		`FOTP_OP_READ_ARRAY:  c1 = `FOTP_CMD_READ_ARRAY;
		`FOTP_OP_READ_ID:     c1 = `FOTP_CMD_READ_ID;
		`FOTP_OP_READ_STATUS: c1 = `FOTP_CMD_READ_STATUS;
		`FOTP_OP_CLR_STATUS:  c1 = `FOTP_CMD_CLR_STATUS;
		`FOTP_OP_QUERY:       c1 = `FOTP_CMD_QUERY;
		`FOTP_OP_OTP_PROG: begin
			c1  = `FOTP_CMD_OTP_SETUP;
			two = 1'b1;
			a2  = otp_addr;
		end
		`FOTP_OP_OTP_LOCK: begin
			c1  = `FOTP_CMD_OTP_SETUP;
			two = 1'b1;
			a2  = {{(AW-9){1'b0}}, `FOTP_AREA_BASE};
			d2  = `FOTP_LOCK_USER_VALUE;
		end
		`FOTP_OP_PROG: begin
			c1  = data_i[DW-1] ? `FOTP_CMD_PROG_ALT : `FOTP_CMD_PROG_WORD;
			two = 1'b1;
			d2  = {1'b0, data_i[DW-2:0]};
		end
		`FOTP_OP_BUF_PROG: begin
			c1  = `FOTP_CMD_BUF_SETUP;
			two = 1'b1;
			d2  = `FOTP_CMD_CONFIRM;
		end
		`FOTP_OP_ERASE: begin
			c1  = `FOTP_CMD_ERASE_SETUP;
			two = 1'b1;
			d2  = `FOTP_CMD_CONFIRM;
		end
		`FOTP_OP_SUSPEND:     c1 = `FOTP_CMD_SUSPEND;
		`FOTP_OP_RESUME:      c1 = `FOTP_CMD_CONFIRM;
		`FOTP_OP_LOCK_BLOCK: begin
			c1  = `FOTP_CMD_LOCK_SETUP;
			two = 1'b1;
			d2  = `FOTP_CMD_LOCK_BLOCK;
		end
		`FOTP_OP_UNLOCK_ALL: begin
			c1  = `FOTP_CMD_LOCK_SETUP;
			two = 1'b1;
			d2  = `FOTP_CMD_CONFIRM;
		end
		`FOTP_OP_STS_CFG: begin
			c1  = `FOTP_CMD_STS_SETUP;
			two = 1'b1;
		end
		`FOTP_OP_ECR: begin
			c1  = `FOTP_CMD_LOCK_SETUP;
			two = 1'b1;
			d2  = `FOTP_CMD_ECR_CONFIRM;
		end
		`FOTP_OP_READ: rd = 1'b1;
		default: c1 = `FOTP_CMD_READ_ARRAY;
		endcase
	end
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q     <= S_IDLE;
			op_q        <= 5'h00;
			addr_q      <= {AW{1'b0}};
			two_q       <= 1'b0;
			rd_q        <= 1'b0;
			cmd1_q      <= {DW{1'b0}};
			a2_q        <= {AW{1'b0}};
			d2_q        <= {DW{1'b0}};
			cyc_start_q <= 1'b0;
			cyc_wr_q    <= 1'b0;
			cyc_addr_q  <= {AW{1'b0}};
			cyc_data_q  <= {DW{1'b0}};
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			rdata_o     <= {DW{1'b0}};
			addr_err_o  <= 1'b0;
		end else begin
			cyc_start_q <= 1'b0;
			done_o      <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (req_i) begin
					op_q       <= op_i;
					addr_q     <= addr_i;
					two_q      <= two;
					rd_q       <= rd;
					cmd1_q     <= c1;
					a2_q       <= a2;
					d2_q       <= d2;
					addr_err_o <= (op_i == `FOTP_OP_OTP_PROG) && aerr;
					busy_o     <= 1'b1;
					state_q    <= S_C1;
				end
			end
			S_C1: begin
				cyc_start_q <= 1'b1;
				cyc_wr_q    <= ~rd_q;
				cyc_addr_q  <= addr_q;
				cyc_data_q  <= cmd1_q;
				state_q     <= S_W1;
			end
			S_W1: begin
				if (cyc_done) begin
					if (rd_q) begin
						rdata_o <= cyc_rdata;
					end
					state_q <= two_q ? S_C2 : S_FIN;
				end
			end
			S_C2: begin
				cyc_start_q <= 1'b1;
				cyc_wr_q    <= 1'b1;
				// ecr value rides the address; otp orders switch to the area address, all others repeat the first address
				cyc_addr_q  <= (op_q == `FOTP_OP_OTP_PROG || op_q == `FOTP_OP_OTP_LOCK)
					? a2_q : addr_q;
				cyc_data_q  <= d2_q;
				state_q     <= S_W2;
			end
			S_W2: begin
				if (cyc_done) begin
					state_q <= S_FIN;
				end
			end
			S_FIN: begin
				busy_o  <= 1'b0;
				done_o  <= 1'b1;
				state_q <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
	// pins come from the cycle engine flops
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fl_addr_o    <= {AW{1'b0}};
			fl_dq_o      <= {DW{1'b0}};
			fl_dq_oe_n_o <= 1'b1;
			fl_ce_n_o    <= 1'b1;
			fl_we_n_o    <= 1'b1;
			fl_oe_n_o    <= 1'b1;
		end else begin
			fl_addr_o    <= cyc_fl_addr;
			fl_dq_o      <= cyc_fl_dq;
			fl_dq_oe_n_o <= cyc_fl_oe_n;
			fl_ce_n_o    <= cyc_ce_n;
			fl_we_n_o    <= cyc_we_n;
			fl_oe_n_o    <= cyc_oe_n;
		end
	end
	fotp_cycle #(
		.AW (AW),
		.DW (DW)
	) u_cycle (
		.mclk_i       (mclk_i),
		.reset_n_i    (reset_n_i),
		.start_i      (cyc_start_q),
		.write_i      (cyc_wr_q),
		.addr_i       (cyc_addr_q),
		.wdata_i      (cyc_data_q),
		.done_o       (cyc_done),
		.rdata_o      (cyc_rdata),
		.fl_addr_o    (cyc_fl_addr),
		.fl_dq_o      (cyc_fl_dq),
		.fl_dq_oe_n_o (cyc_fl_oe_n),
		.fl_dq_i      (fl_dq_i),
		.fl_ce_n_o    (cyc_ce_n),
		.fl_we_n_o    (cyc_we_n),
		.fl_oe_n_o    (cyc_oe_n)
	);
endmodule // fotp_ctrl

// *** verilog/fotp_cycle.v ***
`timescale 1ns/1ns
`include "fotp_defs.vh"
// one asynchronous bus write or read cycle
module fotp_cycle #(
	parameter AW = 24,
	parameter DW = 16
) (
	// clock and reset
	input  wire          mclk_i,
	input  wire          reset_n_i,
	// request
	input  wire          start_i,
	input  wire          write_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	output reg           done_o,
	output reg  [DW-1:0] rdata_o,
	// pins
	output reg  [AW-1:0] fl_addr_o,
	output reg  [DW-1:0] fl_dq_o,
	output reg           fl_dq_oe_n_o,
	input  wire [DW-1:0] fl_dq_i,
	output reg           fl_ce_n_o,
	output reg           fl_we_n_o,
	output reg           fl_oe_n_o
);
	localparam integer WE_CYC = (`FOTP_T_WE_NS + `FOTP_CLK_NS - 1) / `FOTP_CLK_NS;
	localparam integer RD_CYC = (`FOTP_T_RD_NS + `FOTP_CLK_NS - 1) / `FOTP_CLK_NS;
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ACT  = 2'h1;
	localparam [1:0] S_REC  = 2'h2;
	reg [1:0] state_q;
	reg [3:0] cnt_q;
	reg       wr_q;
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q      <= S_IDLE;
			cnt_q        <= 4'h0;
			wr_q         <= 1'b0;
			done_o       <= 1'b0;
			rdata_o      <= {DW{1'b0}};
			fl_addr_o    <= {AW{1'b0}};
			fl_dq_o      <= {DW{1'b0}};
			fl_dq_oe_n_o <= 1'b1;
			fl_ce_n_o    <= 1'b1;
			fl_we_n_o    <= 1'b1;
			fl_oe_n_o    <= 1'b1;
		end else begin
			done_o <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (start_i) begin
					wr_q         <= write_i;
					fl_addr_o    <= addr_i;
					fl_dq_o      <= wdata_i;
					fl_dq_oe_n_o <= ~write_i;
					fl_ce_n_o    <= 1'b0;
					fl_we_n_o    <= ~write_i;
					fl_oe_n_o    <= write_i;
					cnt_q        <= write_i ? WE_CYC[3:0] : RD_CYC[3:0];
					state_q      <= S_ACT;
				end
			end
			S_ACT: begin
				if (cnt_q > 4'h1) begin
					cnt_q <= cnt_q - 4'h1;
				end else begin
					if (!wr_q) begin
						rdata_o <= fl_dq_i;
					end
					fl_we_n_o <= 1'b1;
					fl_oe_n_o <= 1'b1;
					fl_ce_n_o <= 1'b1;
					state_q   <= S_REC;
				end
			end
			S_REC: begin
				fl_dq_oe_n_o <= 1'b1;
				done_o       <= 1'b1;
				state_q      <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule // fotp_cycle

// *** verilog/fotp_defs.vh ***
`ifndef FOTP_DEFS_VH
`define FOTP_DEFS_VH
// command codes
`define FOTP_CMD_READ_ARRAY   16'h00FF
`define FOTP_CMD_READ_ID      16'h0090
`define FOTP_CMD_READ_STATUS  16'h0070
`define FOTP_CMD_CLR_STATUS   16'h0050
`define FOTP_CMD_QUERY        16'h0098
`define FOTP_CMD_OTP_SETUP    16'h00C0
`define FOTP_CMD_PROG_WORD    16'h0040
`define FOTP_CMD_PROG_ALT     16'h0010
`define FOTP_CMD_BUF_SETUP    16'h00E8
`define FOTP_CMD_CONFIRM      16'h00D0
`define FOTP_CMD_ERASE_SETUP  16'h0020
`define FOTP_CMD_SUSPEND      16'h00B0
`define FOTP_CMD_LOCK_SETUP   16'h0060
`define FOTP_CMD_LOCK_BLOCK   16'h0001
`define FOTP_CMD_STS_SETUP    16'h00B8
`define FOTP_CMD_ECR_CONFIRM  16'h0004
`define FOTP_LOCK_USER_VALUE  16'hFFFD
// operation codes on op_i
`define FOTP_OP_READ_ARRAY    5'h00
`define FOTP_OP_READ_ID       5'h01
`define FOTP_OP_READ_STATUS   5'h02
`define FOTP_OP_CLR_STATUS    5'h03
`define FOTP_OP_QUERY         5'h04
`define FOTP_OP_OTP_PROG      5'h05
`define FOTP_OP_OTP_LOCK      5'h06
`define FOTP_OP_PROG          5'h07
`define FOTP_OP_BUF_PROG      5'h08
`define FOTP_OP_ERASE         5'h09
`define FOTP_OP_SUSPEND       5'h0A
`define FOTP_OP_RESUME        5'h0B
`define FOTP_OP_LOCK_BLOCK    5'h0C
`define FOTP_OP_UNLOCK_ALL    5'h0D
`define FOTP_OP_STS_CFG       5'h0E
`define FOTP_OP_ECR           5'h0F
`define FOTP_OP_READ          5'h10
// protection area address map
`define FOTP_AREA_BASE        9'h100
`define FOTP_LOCK_WORD_IDX    3'h0
// status bits
`define FOTP_SR_READY_BIT     7
`define FOTP_SR_PROG_ERR_BIT  4
`define FOTP_SR_LOCK_ERR_BIT  1
// bus timing
`define FOTP_T_WE_NS          70
`define FOTP_T_RD_NS          100
`define FOTP_CLK_NS           40
`endif
